// file: hdl/video_mode_timing_pkg.sv
// Purpose: shared types, mode table and power constants for the display input block
// Assumes: line counts as seen at the display input, one sys clock of 25 ns
// Notes:   pixel-rate figures are the host's business; only line figures are checked
package video_mode_timing_pkg;

    localparam int LINE_W = 11;
    typedef logic [LINE_W-1:0] line_t;

    // supported input formats
    typedef enum logic [3:0] {
        MODE_SVGA_85, MODE_SVGA_75, MODE_SVGA_72, MODE_SVGA_60,
        MODE_VGA_85, MODE_VGA_75, MODE_VGA_72, MODE_VGA_60,
        MODE_NTSC_I, MODE_PAL_I,
        MODE_WIDE_85, MODE_WIDE_75, MODE_WIDE_60,
        MODE_ZOOM_75, MODE_ZOOM_60
    } video_mode_e;

    // per-mode vertical figures
    typedef struct packed {
        line_t total;
        line_t active;
        line_t sync;
        logic  sync_high;
        logic  interlaced;
    } mode_param_s;

    // one enable per powered block, bit 7 first
    typedef struct packed {
        logic pll;
        logic sync_sep;
        logic mono_buf;
        logic rgb_buf;
        logic row_drv;
        logic col_drv;
        logic vref;
        logic seq;
    } block_pwr_s;

    localparam line_t ACT_600      = 11'h258;
    localparam line_t ACT_480      = 11'h1E0;
    localparam line_t ACT_240      = 11'h0F0;
    localparam line_t ACT_288      = 11'h120;
    localparam line_t SVGA85_TOT   = 11'h277;   // 631
    localparam line_t SVGA85_VS    = 11'h003;
    localparam line_t SVGA75_TOT   = 11'h271;   // 625
    localparam line_t SVGA75_VS    = 11'h003;
    localparam line_t SVGA72_TOT   = 11'h29A;   // 666
    localparam line_t SVGA72_VS    = 11'h006;
    localparam line_t SVGA60_TOT   = 11'h274;   // 628
    localparam line_t SVGA60_VS    = 11'h004;
    localparam line_t VGA85_TOT    = 11'h1FD;   // 509
    localparam line_t VGA85_VS     = 11'h003;
    localparam line_t VGA75_TOT    = 11'h1F4;   // 500
    localparam line_t VGA75_VS     = 11'h003;
    localparam line_t VGA72_TOT    = 11'h208;   // 520
    localparam line_t VGA72_VS     = 11'h003;
    localparam line_t VGA60_TOT    = 11'h20D;   // 525
    localparam line_t VGA60_VS     = 11'h002;
    localparam line_t NTSC_TOT     = 11'h106;   // 262, field alternates with 263
    localparam line_t PAL_TOT      = 11'h138;   // 312, field alternates with 313
    localparam line_t WIDE85_TOT   = 11'h1FD;
    localparam line_t WIDE85_VS    = 11'h003;
    localparam line_t WIDE75_TOT   = 11'h1F4;
    localparam line_t WIDE75_VS    = 11'h003;
    localparam line_t WIDE60_TOT   = 11'h20D;
    localparam line_t WIDE60_VS    = 11'h006;
    localparam line_t ZOOM75_TOT   = 11'h271;
    localparam line_t ZOOM75_VS    = 11'h003;
    localparam line_t ZOOM60_TOT   = 11'h274;
    localparam line_t ZOOM60_VS    = 11'h004;
    localparam line_t VS_UNCHECKED = 11'h000;   // interlaced sync width not checked

    // power control
    localparam int             SLEEP_BIT     = 7;
    localparam logic [7:0]     SHUTDOWN_ALL  = 8'hFF;
    localparam logic [7:0]     BLOCK_PWR_RST = 8'h00;
    localparam logic           SERIAL_ON_RST = 1'b1;

    // sync loss watchdog, a least time so round up
    localparam int             CLK_PERIOD_PS = 25000;
    localparam int             SYNC_LOSS_NS  = 100000;
    localparam int             SYNC_LOSS_CYC = (SYNC_LOSS_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int             IDLE_W        = 12;

    // vertical figures of a mode
    function automatic mode_param_s mode_params(input video_mode_e m);
        mode_param_s p;
        p = '{total: SVGA60_TOT, active: ACT_600, sync: SVGA60_VS,
              sync_high: 1'b1, interlaced: 1'b0};
        case (m)
            MODE_SVGA_85: p = '{SVGA85_TOT, ACT_600, SVGA85_VS, 1'b1, 1'b0};
            MODE_SVGA_75: p = '{SVGA75_TOT, ACT_600, SVGA75_VS, 1'b1, 1'b0};
            MODE_SVGA_72: p = '{SVGA72_TOT, ACT_600, SVGA72_VS, 1'b1, 1'b0};
            MODE_SVGA_60: p = '{SVGA60_TOT, ACT_600, SVGA60_VS, 1'b1, 1'b0};
            MODE_VGA_85:  p = '{VGA85_TOT, ACT_480, VGA85_VS, 1'b0, 1'b0};
            MODE_VGA_75:  p = '{VGA75_TOT, ACT_480, VGA75_VS, 1'b0, 1'b0};
            MODE_VGA_72:  p = '{VGA72_TOT, ACT_480, VGA72_VS, 1'b0, 1'b0};
            MODE_VGA_60:  p = '{VGA60_TOT, ACT_480, VGA60_VS, 1'b0, 1'b0};
            MODE_NTSC_I:  p = '{NTSC_TOT, ACT_240, VS_UNCHECKED, 1'b0, 1'b1};
            MODE_PAL_I:   p = '{PAL_TOT, ACT_288, VS_UNCHECKED, 1'b0, 1'b1};
            MODE_WIDE_85: p = '{WIDE85_TOT, ACT_480, WIDE85_VS, 1'b0, 1'b0};
            MODE_WIDE_75: p = '{WIDE75_TOT, ACT_480, WIDE75_VS, 1'b0, 1'b0};
            MODE_WIDE_60: p = '{WIDE60_TOT, ACT_480, WIDE60_VS, 1'b0, 1'b0};
            MODE_ZOOM_75: p = '{ZOOM75_TOT, ACT_600, ZOOM75_VS, 1'b0, 1'b0};
            MODE_ZOOM_60: p = '{ZOOM60_TOT, ACT_600, ZOOM60_VS, 1'b0, 1'b0};
            default:      p = '{SVGA60_TOT, ACT_600, SVGA60_VS, 1'b1, 1'b0};
        endcase
        return p;
    endfunction

endpackage

// file: hdl/pin_sync.sv
// Purpose: two-stage synchroniser with edge pulses for pin inputs
// Assumes: pins are asynchronous to clk_sys_i
// Notes:   edges come from stage two and three only
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] stable_reg;
    logic [W-1:0] last_reg;

    // stage one feeds only stage two
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            meta_reg   <= '0;
            stable_reg <= '0;
            last_reg   <= '0;
        end
        else
        begin
            meta_reg   <= pin_i;
            stable_reg <= meta_reg;
            last_reg   <= stable_reg;
        end
    end

    // edge pulses, one cycle each
    assign level_o = stable_reg;
    assign rise_o  = stable_reg & ~last_reg;
    assign fall_o  = ~stable_reg & last_reg;
endmodule

// file: hdl/video_mode_timing.sv
// Purpose: display-side sync checker and block power control
// Assumes: config inputs come from the register file on clk_sys_i
// Notes:   syncs are sampled at 40 MHz, so only line figures are verified
`timescale 1ns/1ps
// Contract
// - auto mode powers off unused blocks
// - manual mode: shutdown bits per block
// - sleep bit plus all shutdown bits
// - sleep keeps registers and serial port
module video_mode_timing
    import video_mode_timing_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        hsync_pin_i,
    input  wire logic        vsync_pin_i,
    input  video_mode_e      mode_sel_i,
    input  wire logic        auto_pd_i,
    input  wire logic        color_mono_i,
    input  wire logic [7:0]  block_shutdown_register_i,
    input  wire logic [7:0]  analog_bias_register_i,
    output block_pwr_s       block_pwr_o,
    output logic             sleep_o,
    output logic             serial_port_on_o,
    output line_t            frame_lines_o,
    output line_t            vsync_lines_o,
    output logic             frame_done_o,
    output logic             timing_ok_o,
    output logic             sync_lost_o
);
    logic [1:0]  pin_level;
    logic [1:0]  pin_rise;
    logic [1:0]  pin_fall;
    mode_param_s param;
    logic        h_lead;
    logic        v_lead;
    logic        v_trail;
    logic        v_active;
    logic        total_ok;
    logic        sync_ok;

    line_t       line_cnt_reg, line_cnt_next;
    line_t       vs_cnt_reg, vs_cnt_next;
    line_t       frame_lines_reg, frame_lines_next;
    line_t       vs_lines_reg, vs_lines_next;
    logic        frame_done_reg, frame_done_next;
    logic        timing_ok_reg, timing_ok_next;
    logic [IDLE_W-1:0] idle_reg, idle_next;
    block_pwr_s  pwr_reg, pwr_next;
    block_pwr_s  auto_pwr;
    logic        sleep_reg, sleep_next;
    logic        serial_on_reg, serial_on_next;

    // pins are asynchronous, two flops before use
    pin_sync #(
        .W (2)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .pin_i     ({vsync_pin_i, hsync_pin_i}),
        .level_o   (pin_level),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    assign param    = mode_params(mode_sel_i);
    // negative polarity picks falling edge as leading
    assign h_lead   = param.sync_high ? pin_rise[0] : pin_fall[0];
    assign v_lead   = param.sync_high ? pin_rise[1] : pin_fall[1];
    assign v_trail  = param.sync_high ? pin_fall[1] : pin_rise[1];
    assign v_active = pin_level[1] ~^ param.sync_high;

    // fields alternate floor and ceiling of the half line
    assign total_ok = (frame_lines_reg == param.total) ||
                      (param.interlaced && (frame_lines_reg == line_t'(param.total + 1'b1)));
    // sync width in lines, interlaced not checked
    assign sync_ok  = (param.sync == VS_UNCHECKED) || (vs_lines_reg == param.sync);

    // line and sync counters, restarted at each frame
    always_comb
    begin
        line_cnt_next    = line_cnt_reg;
        vs_cnt_next      = vs_cnt_reg;
        frame_lines_next = frame_lines_reg;
        vs_lines_next    = vs_lines_reg;
        frame_done_next  = 1'b0;
        timing_ok_next   = timing_ok_reg;
        // frame boundary at sync leading edge
        if (v_lead)
        begin
            frame_lines_next = line_cnt_reg;
            line_cnt_next    = '0;
            vs_cnt_next      = '0;
            frame_done_next  = 1'b1;
        end
        else if (h_lead)
        begin
            line_cnt_next = line_t'(line_cnt_reg + 1'b1);
            if (v_active)
            begin
                vs_cnt_next = line_t'(vs_cnt_reg + 1'b1);
            end
        end
        if (v_trail)
        begin
            vs_lines_next = vs_cnt_reg;
        end
        // frame totals judged one cycle after latch
        if (frame_done_reg)
        begin
            timing_ok_next = total_ok && sync_ok;
        end
    end

    // watchdog saturates so a dead link stays flagged
    always_comb
    begin
        idle_next = idle_reg;
        if (h_lead)
        begin
            idle_next = '0;
        end
        else if (idle_reg != IDLE_W'(SYNC_LOSS_CYC))
        begin
            idle_next = IDLE_W'(idle_reg + 1'b1);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            line_cnt_reg    <= '0;
            vs_cnt_reg      <= '0;
            frame_lines_reg <= '0;
            vs_lines_reg    <= '0;
            frame_done_reg  <= 1'b0;
            timing_ok_reg   <= 1'b0;
            idle_reg        <= '0;
        end
        else
        begin
            line_cnt_reg    <= line_cnt_next;
            vs_cnt_reg      <= vs_cnt_next;
            frame_lines_reg <= frame_lines_next;
            vs_lines_reg    <= vs_lines_next;
            frame_done_reg  <= frame_done_next;
            timing_ok_reg   <= timing_ok_next;
            idle_reg        <= idle_next;
        end
    end

    // auto mode keeps only what the format needs
    always_comb
    begin
        auto_pwr          = block_pwr_s'(SHUTDOWN_ALL);
        auto_pwr.sync_sep = param.interlaced;
        auto_pwr.mono_buf = color_mono_i;
    end

    // power control; sleep overrides both modes
    always_comb
    begin
        // sleep needs bias bit and every shutdown bit
        sleep_next     = analog_bias_register_i[SLEEP_BIT] &&
                         (block_shutdown_register_i == SHUTDOWN_ALL);
        // serial port stays alive while asleep
        serial_on_next = SERIAL_ON_RST;
        if (sleep_next)
        begin
            pwr_next = block_pwr_s'(BLOCK_PWR_RST);
        end
        else if (auto_pd_i)
        begin
            pwr_next = auto_pwr;
        end
        else
        begin
            // each shutdown bit kills one block
            pwr_next = block_pwr_s'(~block_shutdown_register_i);
        end
    end

    // register contents live outside, so sleep cannot disturb them
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pwr_reg       <= block_pwr_s'(BLOCK_PWR_RST);
            sleep_reg     <= 1'b0;
            serial_on_reg <= SERIAL_ON_RST;
        end
        else
        begin
            pwr_reg       <= pwr_next;
            sleep_reg     <= sleep_next;
            serial_on_reg <= serial_on_next;
        end
    end

    assign block_pwr_o      = pwr_reg;
    assign sleep_o          = sleep_reg;
    assign serial_port_on_o = serial_on_reg;
    assign frame_lines_o    = frame_lines_reg;
    assign vsync_lines_o    = vs_lines_reg;
    assign frame_done_o     = frame_done_reg;
    assign timing_ok_o      = timing_ok_reg;
    assign sync_lost_o      = (idle_reg == IDLE_W'(SYNC_LOSS_CYC));

    // checks on power and frame bookkeeping
    sleep_all_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (analog_bias_register_i[SLEEP_BIT] && block_shutdown_register_i == SHUTDOWN_ALL)
        |=> (sleep_o && block_pwr_o == block_pwr_s'(BLOCK_PWR_RST)))
        else $error("sleep request did not power everything down");

    manual_map_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (!auto_pd_i && !analog_bias_register_i[SLEEP_BIT])
        |=> (block_pwr_o == block_pwr_s'(~$past(block_shutdown_register_i))))
        else $error("manual power map does not follow shutdown bits");

    auto_sep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (auto_pd_i && !sleep_next)
        |=> (block_pwr_o.sync_sep == $past(param.interlaced)
             && block_pwr_o.mono_buf == $past(color_mono_i) && block_pwr_o.pll))
        else $error("auto mode left an unused block powered");

    serial_live_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sleep_o [*3] |-> serial_port_on_o)
        else $error("serial port dropped during sleep");

    frame_latch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        v_lead |=> (frame_done_o && frame_lines_o == $past(line_cnt_reg)
                    && line_cnt_reg == '0) ##1 !frame_done_o)
        else $error("frame count not latched at frame start");

    cover_sleep_c:  cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(sleep_o));
    cover_frame_c:  cover property (@(posedge clk_sys_i) disable iff (reset_i)
        frame_done_o ##1 timing_ok_o);
    cover_lost_c:   cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(sync_lost_o));
    cover_manual_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        !auto_pd_i && !sleep_o ##1 block_pwr_o != block_pwr_s'(SHUTDOWN_ALL));
endmodule

// file: testbench/host_sync_gen.sv
// Purpose: host timing generator model driving the sync pins
// Assumes: one line lasts LINE_CYC sys clocks, pixel counts scaled down
// Notes:   line and frame counts are exact, only the line length shrinks
`timescale 1ns/1ps
module host_sync_gen
    import video_mode_timing_pkg::*;
#(
    parameter int LINE_CYC = 8,
    parameter int HS_POS   = 4,
    parameter int HS_CYC   = 3
) (
    input  wire logic clk_sys_i,
    input  wire logic run_i,
    input  wire logic sync_high_i,
    input  line_t     total_i,
    input  line_t     vs_start_i,
    input  line_t     vs_w_i,
    output logic      hsync_o,
    output logic      vsync_o
);
    int    pix;
    line_t line;
    logic  hs_act;
    logic  vs_act;

    // pixel and line position, restarts when stopped
    always @(posedge clk_sys_i)
    begin
        if (!run_i)
        begin
            pix  <= 0;
            line <= 11'h000;
        end
        else if (pix == LINE_CYC - 1)
        begin
            pix  <= 0;
            line <= (line == total_i - 11'h001) ? 11'h000 : line + 11'h001;
        end
        else
            pix <= pix + 1;
    end

    // vsync moves at line start, ahead of that line's hsync
    // active porch sync order
    assign hs_act = run_i && pix >= HS_POS && pix < HS_POS + HS_CYC;
    assign vs_act = run_i && line >= vs_start_i && line < vs_start_i + vs_w_i;
    assign hsync_o = sync_high_i ? hs_act : !hs_act;
    assign vsync_o = sync_high_i ? vs_act : !vs_act;
endmodule

// file: testbench/video_mode_timing_bench.sv
// Purpose: self-checking bench for the display input block
// Assumes: host model lines of 6 sys clocks
// Notes:   each mode runs two frames, the second one is judged
`timescale 1ns/1ps
module video_mode_timing_bench
    import video_mode_timing_pkg::*;
;
    logic        clk_sys_i  = 1'b0;
    logic        reset_i    = 1'b1;
    video_mode_e mode_sel   = MODE_SVGA_60;
    logic        auto_pd    = 1'b1;
    logic        color_mono = 1'b0;
    logic [7:0]  shutdown   = 8'h00;
    logic [7:0]  bias       = 8'h00;
    logic        run        = 1'b0;
    logic        sync_high  = 1'b1;
    line_t       total      = 11'h001;
    line_t       vs_start   = 11'h000;
    line_t       vs_w       = 11'h001;
    logic        hsync;
    logic        vsync;
    block_pwr_s  block_pwr_o;
    logic        sleep_o;
    logic        serial_port_on_o;
    line_t       frame_lines_o;
    line_t       vsync_lines_o;
    logic        frame_done_o;
    logic        timing_ok_o;
    logic        sync_lost_o;
    int          error_cnt       = 0;
    int          samples_checked = 0;

    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    video_mode_timing dut_u (
        .clk_sys_i                 (clk_sys_i),
        .reset_i                   (reset_i),
        .hsync_pin_i               (hsync),
        .vsync_pin_i               (vsync),
        .mode_sel_i                (mode_sel),
        .auto_pd_i                 (auto_pd),
        .color_mono_i              (color_mono),
        .block_shutdown_register_i (shutdown),
        .analog_bias_register_i    (bias),
        .block_pwr_o               (block_pwr_o),
        .sleep_o                   (sleep_o),
        .serial_port_on_o          (serial_port_on_o),
        .frame_lines_o             (frame_lines_o),
        .vsync_lines_o             (vsync_lines_o),
        .frame_done_o              (frame_done_o),
        .timing_ok_o               (timing_ok_o),
        .sync_lost_o               (sync_lost_o)
    );

    // short lines keep every mode run inside the cycle budget
    host_sync_gen #(
        .LINE_CYC (6),
        .HS_POS   (2),
        .HS_CYC   (3)
    ) gen_u (
        .clk_sys_i   (clk_sys_i),
        .run_i       (run),
        .sync_high_i (sync_high),
        .total_i     (total),
        .vs_start_i  (vs_start),
        .vs_w_i      (vs_w),
        .hsync_o     (hsync),
        .vsync_o     (vsync)
    );

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic check(input string nm, input line_t exp, input line_t got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %0h seen %0h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // bounded wait for the one-cycle frame pulse
    task automatic wait_frame();
        int n;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (frame_done_o !== 1'b1 && n < 12000);
        if (frame_done_o !== 1'b1)
        begin
            $display("Error frame_done expected 1 seen timeout");
            error_cnt++;
            print_verdict();
        end
    endtask

    // power inputs settle, outputs follow one edge later
    task automatic power_case(input logic ap, input logic cm, input video_mode_e m,
                              input logic [7:0] sd, input logic [7:0] ab,
                              input logic [7:0] exp_pwr, input logic exp_slp);
        auto_pd <= ap;
        color_mono <= cm;
        mode_sel <= m;
        shutdown <= sd;
        bias <= ab;
        tick(2);
        check("block_pwr", {3'h0, exp_pwr}, {3'h0, block_pwr_o});
        check("sleep", {10'h000, exp_slp}, {10'h000, sleep_o});
        check("serial_on", 11'h001, {10'h000, serial_port_on_o});
    endtask

    // host sends frames of one mode; the first frame may be partial
    task automatic run_mode(input video_mode_e m, input logic hi, input line_t tot,
                            input line_t vst, input line_t vw, input logic ok);
        mode_sel <= m;
        sync_high <= hi;
        total <= tot;
        vs_start <= vst;
        vs_w <= vw;
        // polarity flips while the host is stopped, so stray edges settle first
        tick(6);
        run <= 1'b1;
        wait_frame();
        wait_frame();
        check("frame_lines", tot, frame_lines_o);
        if (ok)
            check("vsync_lines", vw, vsync_lines_o);
        tick(1);
        check("timing_ok", {10'h000, ok}, {10'h000, timing_ok_o});
        run <= 1'b0;
        tick(1);
    endtask

    // main sequence
    initial
    begin
        tick(3);
        check("pwr_rst", 11'h000, {3'h0, block_pwr_o});
        check("serial_rst", 11'h001, {10'h000, serial_port_on_o});
        reset_i <= 1'b0;
        // power setup done before any video runs
        power_case(1'b1, 1'b0, MODE_SVGA_60, 8'h00, 8'h00, 8'h9F, 1'b0);
        power_case(1'b1, 1'b1, MODE_SVGA_60, 8'h00, 8'h00, 8'hBF, 1'b0);
        power_case(1'b1, 1'b0, MODE_NTSC_I, 8'hFF, 8'h00, 8'hDF, 1'b0);
        power_case(1'b0, 1'b0, MODE_SVGA_60, 8'hA5, 8'h00, 8'h5A, 1'b0);
        power_case(1'b0, 1'b0, MODE_SVGA_60, 8'h5A, 8'h00, 8'hA5, 1'b0);
        power_case(1'b0, 1'b0, MODE_SVGA_60, 8'hFE, 8'h80, 8'h01, 1'b0);
        power_case(1'b0, 1'b0, MODE_SVGA_60, 8'hFF, 8'h80, 8'h00, 1'b1);
        power_case(1'b1, 1'b0, MODE_NTSC_I, 8'hFF, 8'h80, 8'h00, 1'b1);
        power_case(1'b1, 1'b0, MODE_NTSC_I, 8'hFF, 8'h7F, 8'hDF, 1'b0);
        run_mode(MODE_SVGA_85, 1'b1, 11'h277, 11'h259, 11'h003, 1'b1);
        run_mode(MODE_SVGA_85, 1'b1, 11'h276, 11'h259, 11'h003, 1'b0);
        run_mode(MODE_SVGA_72, 1'b1, 11'h29A, 11'h27D, 11'h006, 1'b1);
        run_mode(MODE_VGA_60, 1'b0, 11'h20D, 11'h1EA, 11'h002, 1'b1);
        run_mode(MODE_VGA_60, 1'b1, 11'h20D, 11'h1EA, 11'h002, 1'b0);
        run_mode(MODE_WIDE_60, 1'b0, 11'h20D, 11'h1F0, 11'h006, 1'b1);
        run_mode(MODE_NTSC_I, 1'b0, 11'h107, 11'h0F3, 11'h003, 1'b1);
        run_mode(MODE_SVGA_75, 1'b1, 11'h271, 11'h259, 11'h003, 1'b1);
        run_mode(MODE_SVGA_60, 1'b1, 11'h274, 11'h259, 11'h004, 1'b1);
        run_mode(MODE_VGA_85, 1'b0, 11'h1FD, 11'h1E1, 11'h003, 1'b1);
        run_mode(MODE_VGA_75, 1'b0, 11'h1F4, 11'h1E1, 11'h003, 1'b1);
        run_mode(MODE_VGA_72, 1'b0, 11'h208, 11'h1E9, 11'h003, 1'b1);
        run_mode(MODE_PAL_I, 1'b0, 11'h138, 11'h123, 11'h003, 1'b1);
        // host silent: watchdog must hold off, then flag the loss
        tick(3900);
        check("sync_lost", 11'h000, {10'h000, sync_lost_o});
        tick(200);
        check("sync_lost", 11'h001, {10'h000, sync_lost_o});
        print_verdict();
    end
endmodule
